// file: hdl/lsfc_top.v
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "lsfc_regs.vh"

// How it works
// RL1: five categories, prior traps ranked highest
// RL2: category order fixed, inner order ours
// RL3: unmasked simd fault, support clear: invalid opcode
// RL4: emulation set or fxsr clear: invalid opcode
// RL5: lock prefix gives invalid opcode
// RL6: missing feature flag gives invalid opcode
// RL7: pending x87 fault gives x87 error
// RL8: task switched gives device not available
// RL9: protected illegal stack address: stack fault
// RL10: 64-bit non-canonical stack address: stack fault
// RL11: double group misaligned 16 bytes: protection
// RL12: protected illegal data segment address: protection
// RL13: 64-bit non-canonical data address: protection
// RL14: real/v86 operand beyond ffff: protection
// RL15: page fault outside real mode only
// RL16: single group unaligned at cpl3: alignment check
// RL17: unmasked simd fault, support set: simd fault
module lsfc_top (
  input  wire        mclk_i,              // core clock
  input  wire        rst_n_i,             // async reset, active low
  // ****************************************
  // avalon-mm slave
  // ****************************************
  input  wire [4:0]  avs_address_i,       // byte address
  input  wire        avs_read_i,          // read strobe
  input  wire        avs_write_i,         // write strobe
  input  wire [3:0]  avs_byteenable_i,    // byte lanes
  input  wire [31:0] avs_writedata_i,     // write data
  output wire [31:0] avs_readdata_o,      // read data
  output wire        avs_waitrequest_o,   // wait request
  output wire        irq_o,               // level interrupt
  // ****************************************
  // pipeline check request
  // ****************************************
  input  wire        chk_valid_i, // check strobe, one cycle
  input  wire        prior_trap_i, // trap from previous instruction
  input  wire [7:0]  prior_trap_vec_i, // its vector
  input  wire        ext_intr_i, // external interrupt pending
  input  wire [7:0]  ext_intr_vec_i, // its vector
  input  wire        fetch_fault_i, // next fetch faulted
  input  wire [7:0]  fetch_fault_vec_i, // its vector
  input  wire        decode_fault_i, // next decode faulted
  input  wire [7:0]  decode_fault_vec_i, // its vector
  input  wire [1:0]  mode_i, // operating mode
  input  wire        grp_sgl_i, // single group when high
  input  wire        lock_prefix_i, // lock prefix present
  input  wire        feature_ok_i, // needed feature flags set
  input  wire        x87_pending_i, // pending x87 fault
  input  wire        mem_op_i, // memory operand present
  input  wire        ss_ref_i, // stack segment reference
  input  wire        seg_illegal_i, // illegal segment address
  input  wire        noncanon_i, // non-canonical address
  input  wire [31:0] ea_i, // effective address
  input  wire        pf_i, // translation failure
  input  wire [31:0] pf_code_i, // page fault code
  input  wire        ac_enable_i, // alignment checking enabled
  input  wire [1:0]  cpl_i, // current privilege level
  input  wire        simd_fault_i, // unmasked simd fp fault
  // ****************************************
  // exception delivery
  // ****************************************
  output wire        exc_valid_o, // result strobe, one cycle
  output wire        exc_taken_o, // an event was selected
  output wire [2:0]  exc_cat_o, // winning category
  output wire [7:0]  exc_vec_o, // winning vector
  output wire        exc_has_code_o, // error code valid
  output wire [31:0] exc_code_o // error code
);

  // ****************************************
  // registers
  // ****************************************
  reg  [31:0] cr0_reg;
  reg  [31:0] cr4_reg;
  reg  [7:0]  status_reg;
  reg  [7:0]  status_next;
  reg  [7:0]  mask_reg;
  reg  [10:0] last_reg;
  reg  [31:0] last_code_reg;
  reg         wait_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg         irq_reg;
  reg         exc_valid_reg;
  reg         exc_taken_reg;
  reg  [2:0]  exc_cat_reg;
  reg  [7:0]  exc_vec_reg;
  reg         exc_has_code_reg;
  reg  [31:0] exc_code_reg;

  reg         taken_next;
  reg  [2:0]  cat_next;
  reg  [7:0]  vec_next;
  reg         has_code_next;
  reg  [31:0] code_next;
  reg  [7:0]  hit_next;

  wire [7:0]  ex_hit;
  wire [7:0]  ex_vec;
  wire        ex_has_code;
  wire [31:0] ex_code;

  wire        bus_req  = avs_read_i || avs_write_i;
  wire        bus_go   = bus_req && !wait_reg;
  wire        wr_go    = bus_go && avs_write_i;
  wire        sel_cr0  = (avs_address_i == `LSFC_OFS_CR0);
  wire        sel_cr4  = (avs_address_i == `LSFC_OFS_CR4);
  wire        sel_st   = (avs_address_i == `LSFC_OFS_STATUS);
  wire        sel_mask = (avs_address_i == `LSFC_OFS_MASK);

  // ****************************************
  // execution category table
  // ****************************************
  lsfc_exec_sel u_exec_sel (
    .fpu_emulation_bit_i       (cr0_reg[`LSFC_FPU_EMULATION_BIT_BIT]),
    .task_switched_bit_i       (cr0_reg[`LSFC_TASK_SWITCHED_BIT_BIT]),
    .os_save_restore_support_i (cr4_reg[`LSFC_CR4_FXSR_BIT]),
    .os_simd_fault_support_i   (cr4_reg[`LSFC_CR4_XMMX_BIT]),
    .mode_i                    (mode_i),
    .grp_sgl_i                 (grp_sgl_i),
    .lock_prefix_i             (lock_prefix_i),
    .feature_ok_i              (feature_ok_i),
    .x87_pending_i             (x87_pending_i),
    .mem_op_i                  (mem_op_i),
    .ss_ref_i                  (ss_ref_i),
    .seg_illegal_i             (seg_illegal_i),
    .noncanon_i                (noncanon_i),
    .ea_i                      (ea_i),
    .pf_i                      (pf_i),
    .pf_code_i                 (pf_code_i),
    .ac_enable_i               (ac_enable_i),
    .cpl_i                     (cpl_i),
    .simd_fault_i              (simd_fault_i),
    .hit_o                     (ex_hit),
    .vec_o                     (ex_vec),
    .has_code_o                (ex_has_code),
    .code_o                    (ex_code)
  );

  // ****************************************
  // category ranking
  // ****************************************
  // outer categories carry their own vector; error codes for them are
  // the pipeline's business, so none is reported here
  always @* begin
    taken_next    = 1'b1;
    cat_next      = `LSFC_CAT_NONE;
    vec_next      = 8'h00;
    has_code_next = 1'b0;
    code_next     = 32'h0000_0000;
    hit_next      = 8'h00;
    if (prior_trap_i) begin // see RL1
      cat_next = `LSFC_CAT_TRAP;
      vec_next = prior_trap_vec_i;
    end else if (ext_intr_i) begin // see RL2
      cat_next = `LSFC_CAT_INTR;
      vec_next = ext_intr_vec_i;
    end else if (fetch_fault_i) begin // see RL1
      cat_next = `LSFC_CAT_FETCH;
      vec_next = fetch_fault_vec_i;
    end else if (decode_fault_i) begin // see RL1
      cat_next = `LSFC_CAT_DECODE;
      vec_next = decode_fault_vec_i;
    end else if (ex_hit != 8'h00) begin // see RL2
      cat_next      = `LSFC_CAT_EXEC;
      vec_next      = ex_vec;
      has_code_next = ex_has_code;
      code_next     = ex_code;
      hit_next      = ex_hit;
    end else begin
      taken_next = 1'b0;
    end
  end

  // ****************************************
  // delivery outputs
  // ****************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exc_valid_reg    <= 1'b0;
      exc_taken_reg    <= 1'b0;
      exc_cat_reg      <= `LSFC_CAT_NONE;
      exc_vec_reg      <= 8'h00;
      exc_has_code_reg <= 1'b0;
      exc_code_reg     <= 32'h0000_0000;
    end else begin
      exc_valid_reg <= chk_valid_i;
      if (chk_valid_i) begin
        exc_taken_reg    <= taken_next;
        exc_cat_reg      <= cat_next;
        exc_vec_reg      <= vec_next;
        exc_has_code_reg <= has_code_next;
        exc_code_reg     <= code_next;
      end
    end
  end

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  // a fault in the cycle of a clearing write stays set
  always @* begin
    status_next = status_reg;
    if (wr_go && sel_st && avs_byteenable_i[0]) begin
      status_next = status_next & ~avs_writedata_i[7:0];
    end
    if (chk_valid_i) begin
      status_next = status_next | hit_next;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg    <= `LSFC_STATUS_RST;
      irq_reg       <= 1'b0;
      last_reg      <= 11'h000;
      last_code_reg <= 32'h0000_0000;
    end else begin
      status_reg <= status_next;
      irq_reg    <= (status_next & mask_reg) != 8'h00;
      if (chk_valid_i && taken_next) begin
        last_reg      <= {cat_next, vec_next};
        last_code_reg <= code_next;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // only the four control bits are stored; other bits read as zero
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cr0_reg  <= `LSFC_CR0_RST;
      cr4_reg  <= `LSFC_CR4_RST;
      mask_reg <= `LSFC_MASK_RST;
    end else if (wr_go) begin
      if (sel_cr0 && avs_byteenable_i[0]) begin
        cr0_reg[`LSFC_FPU_EMULATION_BIT_BIT] <= avs_writedata_i[`LSFC_FPU_EMULATION_BIT_BIT];
        cr0_reg[`LSFC_TASK_SWITCHED_BIT_BIT] <= avs_writedata_i[`LSFC_TASK_SWITCHED_BIT_BIT];
      end else if (sel_cr4 && avs_byteenable_i[1]) begin
        cr4_reg[`LSFC_CR4_FXSR_BIT] <= avs_writedata_i[`LSFC_CR4_FXSR_BIT];
        cr4_reg[`LSFC_CR4_XMMX_BIT] <= avs_writedata_i[`LSFC_CR4_XMMX_BIT];
      end else if (sel_mask && avs_byteenable_i[0]) begin
        mask_reg <= avs_writedata_i[7:0];
      end
    end
  end

  // ****************************************
  // bus handshake and read mux
  // ****************************************
  // one wait cycle per access; read data are captured as waitrequest
  // drops so that they stand at the completing edge
  always @* begin
    rdata_next = 32'h0000_0000;
    if (sel_cr0) begin
      rdata_next = cr0_reg;
    end else if (sel_cr4) begin
      rdata_next = cr4_reg;
    end else if (sel_st) begin
      rdata_next = {24'h00_0000, status_reg};
    end else if (sel_mask) begin
      rdata_next = {24'h00_0000, mask_reg};
    end else if (avs_address_i == `LSFC_OFS_LAST) begin
      rdata_next = {21'h00_0000, last_reg};
    end else if (avs_address_i == `LSFC_OFS_CODE) begin
      rdata_next = last_code_reg;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (avs_read_i && wait_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_o             = irq_reg;
  assign exc_valid_o       = exc_valid_reg;
  assign exc_taken_o       = exc_taken_reg;
  assign exc_cat_o         = exc_cat_reg;
  assign exc_vec_o         = exc_vec_reg;
  assign exc_has_code_o    = exc_has_code_reg;
  assign exc_code_o        = exc_code_reg;

endmodule

// file: inc/lsfc_regs.vh
`ifndef LSFC_REGS_VH
`define LSFC_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define LSFC_OFS_CR0        5'h00
`define LSFC_OFS_CR4        5'h04
`define LSFC_OFS_STATUS     5'h08
`define LSFC_OFS_MASK       5'h0c
`define LSFC_OFS_LAST       5'h10
`define LSFC_OFS_CODE       5'h14

// ****************************************
// field positions
// ****************************************
`define LSFC_FPU_EMULATION_BIT_BIT     2
`define LSFC_TASK_SWITCHED_BIT_BIT     3
`define LSFC_CR4_FXSR_BIT   9
`define LSFC_CR4_XMMX_BIT   10
`define LSFC_LAST_CAT_LSB   8

// ****************************************
// reset values
// ****************************************
`define LSFC_CR0_RST        32'h0000_0000
`define LSFC_CR4_RST        32'h0000_0000
`define LSFC_STATUS_RST     8'h00
`define LSFC_MASK_RST       8'h00

// ****************************************
// exception vectors
// ****************************************
`define LSFC_VEC_UD         8'h06
`define LSFC_VEC_NM         8'h07
`define LSFC_VEC_SS         8'h0c
`define LSFC_VEC_GP         8'h0d
`define LSFC_VEC_PF         8'h0e
`define LSFC_VEC_MF         8'h10
`define LSFC_VEC_AC         8'h11
`define LSFC_VEC_XM         8'h13

// ****************************************
// status bit positions, one per execution fault
// ****************************************
`define LSFC_ST_UD          0
`define LSFC_ST_NM          1
`define LSFC_ST_MF          2
`define LSFC_ST_SS          3
`define LSFC_ST_GP          4
`define LSFC_ST_PF          5
`define LSFC_ST_AC          6
`define LSFC_ST_XM          7

// ****************************************
// modes and categories
// ****************************************
`define LSFC_MODE_REAL      2'h0
`define LSFC_MODE_V86       2'h1
`define LSFC_MODE_PROT      2'h2
`define LSFC_MODE_LONG      2'h3
`define LSFC_CAT_NONE       3'h0
`define LSFC_CAT_TRAP       3'h1
`define LSFC_CAT_INTR       3'h2
`define LSFC_CAT_FETCH      3'h3
`define LSFC_CAT_DECODE     3'h4
`define LSFC_CAT_EXEC       3'h5
`define LSFC_SEG_LIMIT      33'h0_0000_ffff
`define LSFC_SZ_DBL         33'h0_0000_000f
`define LSFC_SZ_SGL         33'h0_0000_0007

`endif

// file: hdl/lsfc_exec_sel.v
`timescale 1ns/1ns
`include "lsfc_regs.vh"

// ****************************************
// execution-fault selector, combinational
// ****************************************
module lsfc_exec_sel (
  input  wire        fpu_emulation_bit_i, // em control bit
  input  wire        task_switched_bit_i, // ts control bit
  input  wire        os_save_restore_support_i, // fxsr support bit
  input  wire        os_simd_fault_support_i, // simd fault support bit
  input  wire [1:0]  mode_i, // operating mode
  input  wire        grp_sgl_i, // 1 single group, 0 double group
  input  wire        lock_prefix_i, // lock prefix seen
  input  wire        feature_ok_i, // all needed flags set
  input  wire        x87_pending_i, // pending x87 fault
  input  wire        mem_op_i, // memory operand present
  input  wire        ss_ref_i, // operand uses stack segment
  input  wire        seg_illegal_i, // illegal segment address
  input  wire        noncanon_i, // address non-canonical
  input  wire [31:0] ea_i, // effective address
  input  wire        pf_i, // translation failed
  input  wire [31:0] pf_code_i, // page fault code
  input  wire        ac_enable_i, // alignment checking on
  input  wire [1:0]  cpl_i, // privilege level
  input  wire        simd_fault_i, // unmasked simd fp fault
  output reg  [7:0]  hit_o, // one-hot status bit
  output reg  [7:0]  vec_o, // vector
  output reg         has_code_o, // error code pushed
  output reg  [31:0] code_o // error code
);
  wire        is_real = (mode_i == `LSFC_MODE_REAL);
  wire        is_v86  = (mode_i == `LSFC_MODE_V86);
  wire        is_prot = (mode_i == `LSFC_MODE_PROT);
  wire        is_long = (mode_i == `LSFC_MODE_LONG);
  wire [32:0] ea_end  = {1'b0, ea_i} + (grp_sgl_i ? `LSFC_SZ_SGL : `LSFC_SZ_DBL);
  wire        ud_pre  = fpu_emulation_bit_i || !os_save_restore_support_i // see RL4
                        || lock_prefix_i // see RL5
                        || !feature_ok_i; // see RL6
  wire        ss_f    = mem_op_i && ss_ref_i &&
                        ((is_prot && seg_illegal_i) || // see RL9
                         (is_long && noncanon_i)); // see RL10
  wire        al_f    = mem_op_i && !grp_sgl_i && (ea_i[3:0] != 4'h0); // see RL11
  wire        gp_f    = mem_op_i && !ss_ref_i &&
                        ((is_prot && seg_illegal_i) || // see RL12
                         (is_long && noncanon_i)) || // see RL13
                        (mem_op_i && (is_real || is_v86) &&
                         (ea_end > `LSFC_SEG_LIMIT)); // see RL14
  wire        pf_f    = mem_op_i && pf_i && !is_real; // see RL15
  wire        ac_f    = mem_op_i && grp_sgl_i && !is_real && ac_enable_i &&
                        (ea_i[2:0] != 3'h0) && (cpl_i == 2'h3); // see RL16

  // order inside the execution category is ours; mf follows nm as in a
  // real pipeline the state check comes before touching x87 state
  always @* begin
    hit_o      = 8'h00;
    vec_o      = 8'h00;
    has_code_o = 1'b0;
    code_o     = 32'h0000_0000;
    if (ud_pre) begin
      hit_o[`LSFC_ST_UD] = 1'b1;
      vec_o              = `LSFC_VEC_UD;
    end else if (task_switched_bit_i) begin // see RL8
      hit_o[`LSFC_ST_NM] = 1'b1;
      vec_o              = `LSFC_VEC_NM;
    end else if (x87_pending_i) begin // see RL7
      hit_o[`LSFC_ST_MF] = 1'b1;
      vec_o              = `LSFC_VEC_MF;
    end else if (ss_f) begin
      hit_o[`LSFC_ST_SS] = 1'b1;
      vec_o              = `LSFC_VEC_SS;
      has_code_o         = 1'b1;
    end else if (al_f || gp_f) begin
      hit_o[`LSFC_ST_GP] = 1'b1;
      vec_o              = `LSFC_VEC_GP;
      has_code_o         = 1'b1;
    end else if (pf_f) begin
      hit_o[`LSFC_ST_PF] = 1'b1;
      vec_o              = `LSFC_VEC_PF;
      has_code_o         = 1'b1;
      code_o             = pf_code_i;
    end else if (ac_f) begin
      hit_o[`LSFC_ST_AC] = 1'b1;
      vec_o              = `LSFC_VEC_AC;
      has_code_o         = 1'b1;
    end else if (simd_fault_i && !os_simd_fault_support_i) begin // see RL3
      hit_o[`LSFC_ST_UD] = 1'b1;
      vec_o              = `LSFC_VEC_UD;
    end else if (simd_fault_i) begin // see RL17
      hit_o[`LSFC_ST_XM] = 1'b1;
      vec_o              = `LSFC_VEC_XM;
    end
  end

endmodule

// file: dv/lsfc_pipe_model.sv
`timescale 1ns/1ns
// ****************************************
// pipeline model: issues check requests
// ****************************************
module lsfc_pipe_model (
  input  wire logic   mclk_i,  // core clock
  output logic        chk_valid_i = 1'b0,  // check strobe
  output wire         prior_trap_i, ext_intr_i, fetch_fault_i, decode_fault_i, grp_sgl_i,
  output wire         lock_prefix_i, feature_ok_i, x87_pending_i, mem_op_i, ss_ref_i,
  output wire         seg_illegal_i, noncanon_i, pf_i, ac_enable_i, simd_fault_i,
  output logic [1:0]  mode_i = 2'h0, cpl_i = 2'h0,  // mode and privilege
  output wire  [7:0]  prior_trap_vec_i, ext_intr_vec_i, fetch_fault_vec_i, decode_fault_vec_i,
  output logic [31:0] ea_i = 32'h0, pf_code_i = 32'h0  // address and page code
);
  logic [15:0] f = 16'h0;
  logic [7:0]  v = 8'h0;
  assign {prior_trap_i, ext_intr_i, fetch_fault_i, decode_fault_i, grp_sgl_i, lock_prefix_i,
          feature_ok_i, x87_pending_i, mem_op_i, ss_ref_i, seg_illegal_i, noncanon_i, pf_i,
          ac_enable_i, simd_fault_i} = f[15:1];
  assign prior_trap_vec_i = v;
  assign ext_intr_vec_i = v + 8'h01;
  assign fetch_fault_vec_i = v + 8'h02;
  assign decode_fault_vec_i = v + 8'h03;
  // hold keeps the strobe up so the next call lands back to back
  task automatic issue(input logic [15:0] nf, input logic [1:0] nm, nc, input logic [7:0] nv,
                       input logic [31:0] ne, np, input logic hold);
    chk_valid_i <= 1'b1;
    f <= nf;
    mode_i <= nm;
    cpl_i <= nc;
    v <= nv;
    ea_i <= ne;
    pf_code_i <= np;
    @(posedge mclk_i);
    if (!hold) begin
      chk_valid_i <= 1'b0;
      f <= ~nf;  // stale fields other than mode and privilege never repeat the sampled values
      v <= ~nv;
      ea_i <= ~ne;
      pf_code_i <= ~np;
      @(posedge mclk_i);
    end
  endtask
endmodule

// file: dv/lsfc_top_asserts.sv
`timescale 1ns/1ns
`include "lsfc_regs.vh"
// ****************************************
// port checker
// ****************************************
module lsfc_top_asserts (
  input logic       mclk_i, // clock
  input logic       rst_n_i, // reset
  input logic       avs_read_i, // read
  input logic       avs_write_i, // write
  input logic       avs_waitrequest_o, // wait
  input logic       chk_valid_i, // check strobe
  input logic       prior_trap_i, // trap
  input logic       ext_intr_i, // interrupt
  input logic       fetch_fault_i, // fetch fault
  input logic       decode_fault_i, // decode fault
  input logic       lock_prefix_i, // lock
  input logic       exc_valid_o, // result strobe
  input logic       exc_taken_o, // taken
  input logic [2:0] exc_cat_o, // category
  input logic [7:0] exc_vec_o // vector
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire no_outer = !prior_trap_i && !ext_intr_i && !fetch_fault_i && !decode_fault_i;
  property p_answer; chk_valid_i |=> exc_valid_o; endproperty
  a_answer: assert property (p_answer) else $error("no result after check");
  property p_trap; chk_valid_i && prior_trap_i |=> exc_taken_o && exc_cat_o == `LSFC_CAT_TRAP;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not ranked first");
  property p_intr; chk_valid_i && !prior_trap_i && ext_intr_i |=> exc_cat_o == `LSFC_CAT_INTR;
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt misranked");
  property p_fetch;
    chk_valid_i && !prior_trap_i && !ext_intr_i && fetch_fault_i |=> exc_cat_o == 3'h3;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch fault misranked");
  property p_decode; chk_valid_i && !prior_trap_i && !ext_intr_i && !fetch_fault_i
    && decode_fault_i |=> exc_cat_o == `LSFC_CAT_DECODE; endproperty
  a_decode: assert property (p_decode) else $error("decode fault misranked");
  property p_lock; chk_valid_i && no_outer && lock_prefix_i
    |=> exc_cat_o == `LSFC_CAT_EXEC && exc_vec_o == `LSFC_VEC_UD; endproperty
  a_lock: assert property (p_lock) else $error("lock prefix not refused");
  property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_release; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_release: assert property (p_release) else $error("wait low too long");
  c_trap: cover property (chk_valid_i && prior_trap_i);
  c_exec: cover property (exc_valid_o && exc_cat_o == `LSFC_CAT_EXEC);
  c_bus: cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind lsfc_top lsfc_top_asserts lsfc_top_asserts_inst (.*);

// file: dv/legacy_simd_fault_check_bench.sv
`timescale 1ns/1ns
`include "lsfc_regs.vh"
module legacy_simd_fault_check_bench;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0, q, r, s, ea, pc, cr0s = 32'h0, cr4s = 32'h0;
  wire chk_valid_i, prior_trap_i, ext_intr_i, fetch_fault_i, decode_fault_i, grp_sgl_i;
  wire lock_prefix_i, feature_ok_i, x87_pending_i, mem_op_i, ss_ref_i, seg_illegal_i;
  wire noncanon_i, pf_i, ac_enable_i, simd_fault_i, avs_waitrequest_o, irq_o;
  wire exc_valid_o, exc_taken_o, exc_has_code_o;
  wire [1:0] mode_i, cpl_i;
  wire [2:0] exc_cat_o;
  wire [7:0] prior_trap_vec_i, ext_intr_vec_i, fetch_fault_vec_i, decode_fault_vec_i, exc_vec_o;
  wire [31:0] ea_i, pf_code_i, avs_readdata_o, exc_code_o;
  int n_mismatch = 0, total_checks = 0, seed = 48370;
  logic [52:0] expq[$], e;
  logic [7:0] exp_status = 8'h00;
  logic [15:0] f;
  logic [4:0] regs[5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h18};
  lsfc_top lsfc_top_inst (.*);
  lsfc_pipe_model lsfc_pipe_model_inst (.*);
  initial forever #4 mclk_i = ~mclk_i;
  initial begin
    #400000;
    miss("timeout");
    end_of_test();
  end
  task automatic miss(input string m);
    n_mismatch++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // register bus master
  // ****************************************
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 64);
    if (n >= 64) miss("bus hang");
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);  // keeps strobes from being driven twice in one step
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    total_checks++;
    if (q !== x) miss("register read");
  endtask
  // ****************************************
  // reference selection
  // ****************************************
  function automatic logic [52:0] ex(input int b, input logic [7:0] v, input logic hc,
                                     input logic [31:0] c);
    return {8'h01 << b, 1'b1, hc, `LSFC_CAT_EXEC, v, c};
  endfunction
  function automatic logic [52:0] predict(input logic [15:0] f, input logic [1:0] m, c,
                                          input logic [7:0] v, input logic [31:0] ea, pc);
    logic [32:0] top;
    logic seg;
    top = {1'b0, ea} + (f[11] ? `LSFC_SZ_SGL : `LSFC_SZ_DBL);
    seg = (m == `LSFC_MODE_PROT && f[5]) || (m == `LSFC_MODE_LONG && f[4]);
    if (f[15]) return {10'h002, `LSFC_CAT_TRAP, v, 32'h0};
    if (f[14]) return {10'h002, `LSFC_CAT_INTR, v + 8'h01, 32'h0};
    if (f[13]) return {10'h002, `LSFC_CAT_FETCH, v + 8'h02, 32'h0};
    if (f[12]) return {10'h002, `LSFC_CAT_DECODE, v + 8'h03, 32'h0};
    if (cr0s[2] || !cr4s[9] || f[10] || !f[9]) return ex(0, `LSFC_VEC_UD, 0, 0);
    if (cr0s[3]) return ex(1, `LSFC_VEC_NM, 0, 0);
    if (f[8]) return ex(2, `LSFC_VEC_MF, 0, 0);
    if (f[6] && seg) return ex(3, `LSFC_VEC_SS, 1, 0);
    if (f[7] && ((!f[11] && ea[3:0] != 4'h0) || (!f[6] && seg)
        || (m < 2'h2 && top > `LSFC_SEG_LIMIT))) return ex(4, `LSFC_VEC_GP, 1, 0);
    if (f[3] && m != 2'h0) return ex(5, `LSFC_VEC_PF, 1, pc);
    if (f[11] && m != 2'h0 && f[2] && c == 2'h3 && ea[2:0] != 3'h0)
      return ex(6, `LSFC_VEC_AC, 1, 0);
    if (f[1]) return cr4s[10] ? ex(7, `LSFC_VEC_XM, 0, 0) : ex(0, `LSFC_VEC_UD, 0, 0);
    return 53'h0;
  endfunction
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge mclk_i) begin
    if (exc_valid_o === 1'b1) begin
      total_checks++;
      if (expq.size() == 0) miss("result without check");
      else begin
        e = expq.pop_front();
        exp_status = exp_status | e[52:45];
        if (exc_taken_o !== e[44] || exc_cat_o !== e[42:40] || (e[44] && (exc_vec_o !== e[39:32]
            || exc_has_code_o !== e[43] || exc_code_o !== e[31:0]))) miss("fault selection");
      end
    end
  end
  task automatic check(input logic [15:0] f, input logic [31:0] ea, input logic hold);
    r = $random(seed);
    pc = $random(seed);
    expq.push_back(predict(f, r[1:0], r[3:2], r[11:4], ea, pc));
    lsfc_pipe_model_inst.issue(f, r[1:0], r[3:2], r[11:4], ea, pc, hold);
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (regs[i]) rd(regs[i], 32'h0);
    bus(1'b1, `LSFC_OFS_MASK, 32'hff);
    for (int i = 0; i < 800; i++) begin
      if (i % 16 == 0) begin
        r = $random(seed) & $random(seed);
        s = $random(seed) | $random(seed);
        bus(1'b1, `LSFC_OFS_CR0, r);
        bus(1'b1, `LSFC_OFS_CR4, s);
        cr0s = r & 32'h0c;
        cr4s = s & 32'h600;
        rd(`LSFC_OFS_CR0, cr0s);
        rd(`LSFC_OFS_CR4, cr4s);
      end
      r = $random(seed) & $random(seed) & $random(seed);
      s = $random(seed);
      f = r[15:0] | (s[15:0] & 16'h08c4);
      f[9] = ~f[9];
      ea = s & 32'h0001_ffff;
      if (!f[7]) begin
        f = f & ~16'h007c;  // no memory operand, so no address faults
        ea = 32'h0;
      end
      check(f, ea, i % 16 != 15 && s[31]);
    end
    repeat (3) @(posedge mclk_i);
    total_checks++;
    if (irq_o !== (exp_status != 8'h00)) miss("interrupt level");
    rd(`LSFC_OFS_STATUS, {24'h0, exp_status});
    bus(1'b1, `LSFC_OFS_STATUS, 32'hff);
    exp_status = 8'h00;
    rd(`LSFC_OFS_STATUS, 32'h0);
    bus(1'b1, `LSFC_OFS_MASK, 32'h0);
    check(16'h0600, 32'h0, 1'b0);
    repeat (3) @(posedge mclk_i);
    rd(`LSFC_OFS_STATUS, 32'h1);
    rd(`LSFC_OFS_LAST, {21'h0, `LSFC_CAT_EXEC, `LSFC_VEC_UD});
    rd(`LSFC_OFS_CODE, 32'h0);
    total_checks++;
    if (irq_o !== 1'b0) miss("masked interrupt raised");
    end_of_test();
  end
endmodule
